/* File: channel_bank.sv */
// eight-word register bank with per-word write enables and registered read ports
`timescale 1ns/1ps
`default_nettype none
module channel_bank
    import dac_cmd_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          resetn_i,
    // write side
    input  wire logic [CHANNELS-1:0]           write_i,
    input  wire logic [CHANNELS*DATA_BITS-1:0] wdata_i,
    // read side
    output logic      [CHANNELS*DATA_BITS-1:0] rdata_o
);

    // one register per word, all cleared at reset
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_word
            always_ff @(posedge mclk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    rdata_o[ch*DATA_BITS +: DATA_BITS] <= CODE_RST;
                end else if (write_i[ch]) begin
                    rdata_o[ch*DATA_BITS +: DATA_BITS] <= wdata_i[ch*DATA_BITS +: DATA_BITS];
                end
            end
        end
    endgenerate

endmodule : channel_bank
`default_nettype wire

/* File: dac_cmd_assertions.sv */
// port checks for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_assertions
    import dac_cmd_pkg::*;
(
    // clock, reset, pins and status
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    input wire logic        sclk_i,
    input wire logic        cs_n_i,
    input wire logic        din_i,
    input wire logic        async_update_n_i,
    input wire logic        dout_o,
    input wire logic [63:0] input_code_o,
    input wire logic [63:0] channel_code_o,
    input wire power_type   power_o,
    input wire logic        dout_phase_o
);
    logic       cs_q;
    logic [3:0] since;
    // mclk cycles since chip select rose, saturating
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_q  <= 1'b1;
            since <= 4'hf;
        end else begin
            cs_q  <= cs_n_i;
            since <= (cs_n_i && !cs_q) ? 4'h0 : since + {3'h0, since != 4'hf};
        end
    end
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    ic_hold_a: assert property (!cs_n_i [*6] |-> $stable(input_code_o))
        else $error("input codes moved inside a frame");
    cc_hold_a: assert property ((!cs_n_i && async_update_n_i) [*6] |-> $stable(channel_code_o))
        else $error("channel codes moved inside a frame");
    dout_hold_a: assert property (cs_n_i [*6] |-> $stable(dout_o))
        else $error("serial out moved while deselected");
    phase_hold_a: assert property (!cs_n_i [*6] |-> $stable(dout_phase_o))
        else $error("phase moved inside a frame");
    async_follow_a: assert property ((!async_update_n_i && cs_n_i) [*8] |-> channel_code_o == input_code_o)
        else $error("channel codes not following input codes");
    power_down_a: assert property (power_o.power_down == (power_o.shutdown && power_o.buffer_enable == 8'h00))
        else $error("power-down flag disagrees with mask");
    wake_mask_a: assert property (!power_o.shutdown |-> power_o.buffer_enable == ENABLE_ALL)
        else $error("buffers not all enabled when awake");
    cmd_timing_a: assert property ($changed(input_code_o) || $changed(power_o) || $changed(dout_phase_o)
        |-> since inside {[4'h1:4'h6]})
        else $error("state changed away from a select rise");
endmodule : dac_cmd_assertions
bind octal_dac_serial_command_decoder dac_cmd_assertions u_chk (.mclk_i, .resetn_i, .sclk_i, .cs_n_i, .din_i,
    .async_update_n_i, .dout_o, .input_code_o, .channel_code_o, .power_o, .dout_phase_o);
`default_nettype wire

/* File: dac_cmd_pkg.sv */
// package: serial command decoder constants and types
package dac_cmd_pkg;

    localparam int          WORD_BITS    = 16;
    localparam int          CHANNELS     = 8;
    localparam int          DATA_BITS    = 8;
    localparam logic [4:0]  BIT_COUNT_RST = 5'h00;
    localparam logic [7:0]  CODE_RST     = 8'h00;
    localparam logic [7:0]  ENABLE_ALL   = 8'hff;
    localparam logic        PHASE_RST    = 1'b0;   // falling-edge phase
    // field positions in the 16-bit word
    localparam int          ADDR_POS     = 11;
    localparam int          CTRL_POS     = 8;
    localparam int          DATA_POS     = 0;

    typedef enum logic [2:0] {
        CTRL_NOP        = 3'h0,
        CTRL_CLEAR      = 3'h1,
        CTRL_SHUTDOWN   = 3'h2,
        CTRL_PHASE      = 3'h3,
        CTRL_LOAD_ALL   = 3'h4,
        CTRL_LOAD_INPUT = 3'h5,
        CTRL_LOAD_BOTH  = 3'h6,
        CTRL_UPDATE     = 3'h7
    } control_type;

    // decoded command word, first two bits dropped
    typedef struct packed {
        logic [2:0]  address;
        control_type control;
        logic [7:0]  data;
    } command_type;

    // power status that leaves the block together
    typedef struct packed {
        logic       shutdown;
        logic       power_down;
        logic [7:0] buffer_enable;
    } power_type;

endpackage : dac_cmd_pkg

/* File: octal_dac_serial_command_decoder.sv */
// serial command decoder for an eight-channel 8-bit converter
//
// Contract
// R1 - control 101 loads addressed input register on chip-select rise, outputs kept
// R2 - address 000 picks channel A up to 111 for channel H
// R3 - control 110 loads addressed input and output register, others kept
// R4 - control 111 copies every input register to its output register
// R5 - control 000 only shifts the word, no register changes
// R6 - host sends farthest device word first, nop to devices left alone
// R7 - control 001 zeroes all input and output registers, leaves shutdown
// R8 - shutdown ends only on reset, clear, load-all or load-both
// R9 - control 010 enters shutdown, zero data bits disable buffers
// R10 - shutdown with all data bits zero gives full power-down
// R11 - control 011 with address msb 0 selects falling phase, updates outputs
// R12 - control 011 with address msb 1 selects rising phase, updates outputs
// R13 - phase is latched, changes only on reset or phase command
// R14 - control 100 writes same data to all output registers, leaves shutdown
// R15 - host may load-all with 00 hex instead of clear
// R16 - host may load seven channels then load-both channel H
// R17 - first two word bits ignored, rest are address, control, data
// R18 - async update low makes output registers follow input registers
// R19 - serial output lags 16.5 clocks falling phase, 16 rising phase
// R20 - reset clears interface and registers, selects falling phase
// R21 - host shifts msb first on rising clock, full 16-bit words
// R22 - leaving shutdown re-enables all buffers and drops the mask
`timescale 1ns/1ps
`default_nettype none
module octal_dac_serial_command_decoder
    import dac_cmd_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          resetn_i,
    // serial link pins
    input  wire logic                          sclk_i,
    input  wire logic                          cs_n_i,
    input  wire logic                          din_i,
    input  wire logic                          async_update_n_i,
    output logic                               dout_o,
    // channel codes, channel A in the low byte
    output logic      [CHANNELS*DATA_BITS-1:0] input_code_o,
    output logic      [CHANNELS*DATA_BITS-1:0] channel_code_o,
    // power and phase status
    output power_type                          power_o,
    output logic                               dout_phase_o
);

    // two-flop synchronisers for the pins
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic       sclk_prev;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta  <= 4'ha; // idle levels: select and update high
            pin_sync  <= 4'ha;
            sclk_prev <= 1'b0;
        end else begin
            pin_meta  <= {async_update_n_i, din_i, cs_n_i, sclk_i};
            pin_sync  <= pin_meta;
            sclk_prev <= pin_sync[0];
        end
    end

    // synchronised pin values and edge strobes
    logic sclk_s;
    logic cs_n_s;
    logic din_s;
    logic upd_n_s;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_n_prev;
    logic cs_rise;
    // shift clock edges only count while selected
    assign sclk_s    = pin_sync[0];
    assign cs_n_s    = pin_sync[1];
    assign din_s     = pin_sync[2];
    assign upd_n_s   = pin_sync[3];
    assign sclk_rise = sclk_s & ~sclk_prev & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_prev & ~cs_n_s;
    assign cs_rise   = cs_n_s & ~cs_n_prev;

    // chip select edge history
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_n_prev <= 1'b1;
        end else begin
            cs_n_prev <= cs_n_s;
        end
    end

    // shift register, msb first on rising shift clock
    logic [WORD_BITS-1:0] shift_word;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            shift_word <= '0; // R20
        end else if (sclk_rise) begin
            shift_word <= {shift_word[WORD_BITS-2:0], din_s};
        end
    end

    // serial output: bit 15 on falling edge (16.5 lag) or bit 14 on rising edge (16 lag)
    logic phase_rising;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dout_o <= 1'b0;
        end else if (phase_rising ? sclk_rise : sclk_fall) begin
            dout_o <= phase_rising ? shift_word[WORD_BITS-2] : shift_word[WORD_BITS-1]; // R19
        end
    end

    // decode the last word, top two bits dropped
    command_type cmd;
    assign cmd.address = shift_word[ADDR_POS +: 3];                   // R17
    assign cmd.control = control_type'(shift_word[CTRL_POS +: 3]);
    assign cmd.data    = shift_word[DATA_POS +: DATA_BITS];

    // one-hot channel select from the address field
    function automatic logic [CHANNELS-1:0] channel_select(input logic [2:0] addr);
        channel_select = 8'h01 << addr; // R2
    endfunction : channel_select

    // write strobes and data for both banks
    logic [CHANNELS-1:0]           next_input_write;
    logic [CHANNELS-1:0]           next_output_write;
    logic [CHANNELS*DATA_BITS-1:0] next_input_data;
    logic [CHANNELS*DATA_BITS-1:0] next_output_data;
    logic [CHANNELS*DATA_BITS-1:0] input_bank;
    always_comb begin
        next_input_write  = '0;
        next_output_write = '0;
        next_input_data   = {CHANNELS{cmd.data}};
        next_output_data  = input_bank;
        if (cs_rise) begin
            unique case (cmd.control)
                CTRL_NOP: begin
                    next_input_write = '0;                             // R5
                end
                CTRL_CLEAR: begin
                    next_input_write  = ENABLE_ALL;                    // R7
                    next_output_write = ENABLE_ALL;
                    next_input_data   = '0;
                    next_output_data  = '0;
                end
                CTRL_SHUTDOWN: begin
                    next_input_write = '0;
                end
                CTRL_PHASE, CTRL_UPDATE: begin
                    next_output_write = ENABLE_ALL;                    // R4 R11 R12
                end
                CTRL_LOAD_ALL: begin
                    next_output_write = ENABLE_ALL;                    // R14
                    next_output_data  = {CHANNELS{cmd.data}};
                end
                CTRL_LOAD_INPUT: begin
                    next_input_write = channel_select(cmd.address);    // R1
                end
                CTRL_LOAD_BOTH: begin
                    next_input_write  = channel_select(cmd.address);   // R3
                    next_output_write = channel_select(cmd.address);
                    next_output_data  = {CHANNELS{cmd.data}};
                end
            endcase
        end
        // transparent outputs while async update is low, follow inputs a cycle later
        if (!upd_n_s && next_output_write == '0) begin
            next_output_write = ENABLE_ALL;                            // R18
        end
    end

    // input register bank
    channel_bank input_regs (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .write_i  (next_input_write),
        .wdata_i  (next_input_data),
        .rdata_o  (input_bank)
    );

    // output register bank
    channel_bank output_regs (
        .mclk_i   (mclk_i),
        .resetn_i (resetn_i),
        .write_i  (next_output_write),
        .wdata_i  (next_output_data),
        .rdata_o  (channel_code_o)
    );

    // input codes leave straight from the bank registers
    assign input_code_o = input_bank;

    // phase latch, falling edge after reset
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase_rising <= PHASE_RST;                                 // R20
        end else if (cs_rise && cmd.control == CTRL_PHASE) begin
            phase_rising <= cmd.address[2];                            // R13
        end
    end
    // phase status leaves straight from its flop
    assign dout_phase_o = phase_rising;

    // shutdown state and buffer mask
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            power_o <= '{shutdown: 1'b0, power_down: 1'b0, buffer_enable: ENABLE_ALL};
        end else if (cs_rise) begin
            unique case (cmd.control)
                CTRL_SHUTDOWN: begin
                    power_o <= '{shutdown: 1'b1, power_down: (cmd.data == '0),
                                 buffer_enable: cmd.data};             // R9 R10
                end
                CTRL_CLEAR, CTRL_LOAD_ALL, CTRL_LOAD_BOTH: begin
                    power_o <= '{shutdown: 1'b0, power_down: 1'b0, buffer_enable: ENABLE_ALL}; // R8 R22
                end
                CTRL_NOP, CTRL_PHASE, CTRL_UPDATE, CTRL_LOAD_INPUT: begin
                    power_o <= power_o;                                // R8
                end
            endcase
        end
    end

endmodule : octal_dac_serial_command_decoder
`default_nettype wire

/* File: serial_host_model.sv */
// serial host model: shift clock, chip select and data, captures serial out
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    // link pins
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic din_o,
    input  wire logic dout_i
);
    // idle: clock low, deselected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    // two words msb first, far word first; serial out sampled at each fall of the second
    task automatic send_frame(input logic [31:0] f, output logic [15:0] r);
        r = 16'h0000;
        #7 cs_n_o = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            #100 din_o = f[i];
            #100 sclk_o = 1'b1;
            #200 r[i%16] = dout_i;
            sclk_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        din_o = ~din_o; // released line keeps no stale value
    endtask : send_frame
endmodule : serial_host
`default_nettype wire

/* File: testbench.sv */
// self-checking bench for the serial command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dac_cmd_pkg::*;
    logic        mclk_i, resetn_i, sclk, cs_n, din, upd_n, dout, phase;
    logic [63:0] icode, ccode;
    logic [15:0] rnd, rx;
    power_type   pwr;
    int          bad_count, checks_done, cyc, sd, ph, in_r[8], out_r[8];
    int          mask = 255;
    logic [13:0] plan[15] = '{14'h0700, 14'h1e3c, 14'h28ff, 14'h02a5, 14'h1577, 14'h0700, 14'h0400, 14'h0200,
                              14'h3511, 14'h0100, 14'h020f, 14'h3e99, 14'h2300, 14'h0dc3, 14'h1b00};
    serial_host u_host (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .dout_i(dout));
    octal_dac_serial_command_decoder u_dut (.mclk_i, .resetn_i, .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
        .async_update_n_i(upd_n), .dout_o(dout), .input_code_o(icode), .channel_code_o(ccode),
        .power_o(pwr), .dout_phase_o(phase));
    // 20 MHz clock
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end
    // run limit
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            bad_count++;
            complete_run();
        end
    end
    function automatic logic [15:0] next_rand(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : next_rand
    function automatic logic [63:0] pack(input int r[8]);
        logic [63:0] v;
        for (int i = 0; i < 8; i++)
            v[i*8 +: 8] = r[i][7:0];
        return v;
    endfunction : pack
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one compare task per kind of result
    task automatic check_codes();
        check(icode, pack(in_r));
        check(ccode, pack(out_r));
    endtask : check_codes
    task automatic check_power();
        check({54'h0, pwr}, {54'h0, sd[0], sd[0] && mask == 0, mask[7:0]});
    endtask : check_power
    task automatic check_phase();
        check({63'h0, phase}, {63'h0, ph[0]});
    endtask : check_phase
    task automatic check_serial(input logic [15:0] exp);
        check({48'h0, rx}, {48'h0, exp});
    endtask : check_serial
    task automatic compare_all();
        check_codes();
        check_power();
        check_phase();
    endtask : compare_all
    // one command behind a pass-through word, then model update and compare
    task automatic cmd(input logic [2:0] a, input logic [2:0] c, input logic [7:0] d);
        logic [15:0] p;
        logic [15:0] w;
        p = rnd;
        rnd = next_rand(rnd);
        w = {rnd[15:14], a, c, d};
        rnd = next_rand(rnd);
        u_host.send_frame({p, w}, rx);
        check_serial(ph ? {p[14:0], w[15]} : p);
        if (c == 3'h1) in_r = '{default: 0};
        if (c == 3'h5 || c == 3'h6) in_r[a] = d;
        if (c == 3'h3 || c == 3'h7) out_r = in_r;
        if (c == 3'h1 || c == 3'h4) out_r = '{default: (c == 3'h4) ? d : 0};
        if (c == 3'h6) out_r[a] = d;
        if (c == 3'h3) ph = a[2];
        if (c == 3'h2) mask = d;
        sd = (c == 3'h2) || (sd != 0 && c != 3'h1 && c != 3'h4 && c != 3'h6);
        if (!upd_n) out_r = in_r;
        if (sd == 0) mask = 255;
        repeat (10) @(posedge mclk_i);
        compare_all();
    endtask : cmd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run
    // reset, every channel, directed commands, then random traffic
    initial begin
        resetn_i = 1'b0;
        upd_n = 1'b1;
        rnd = 16'h005a;
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        compare_all();
        for (int i = 0; i < 7; i++) begin
            cmd(i[2:0], 3'h5, rnd[7:0]);
        end
        cmd(3'h7, 3'h6, rnd[7:0]);
        cmd(3'h2, 3'h4, 8'h00);
        foreach (plan[i])
            cmd(plan[i][13:11], plan[i][10:8], plan[i][7:0]);
        for (int i = 0; i < 24; i++) begin
            upd_n <= rnd[3];
            cmd(rnd[13:11], rnd[10:8], rnd[7:0]);
        end
        complete_run();
    end
endmodule : testbench
`default_nettype wire
